// ### eeprom_access_pkg.sv
// constants and carriers for the data-memory access controller
// assumes an 8-bit CPU I/O register port and a 10 MHz system clock
package eeprom_access_pkg;

  // ********************************
  // register map (I/O space offsets)
  // ********************************
  localparam logic [5:0] CONTROL_OFFSET = 6'h1C;
  localparam logic [5:0] DATA_OFFSET = 6'h1D;
  localparam logic [5:0] ADDR_LOW_OFFSET = 6'h1E;
  localparam logic [5:0] ADDR_HIGH_OFFSET = 6'h1F;

  // ********************************
  // control register fields
  // ********************************
  localparam int READ_STROBE_BIT = 0;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int MASTER_WRITE_ENABLE_BIT = 2;
  localparam int READY_IRQ_ENABLE_BIT = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ********************************
  // memory geometry
  // ********************************
  localparam int ADDR_WIDTH = 11;
  localparam int DEPTH = 2048;
  localparam logic [2:0] ADDR_HIGH_MASK = 3'h7;

  // ********************************
  // timing
  // ********************************
  localparam int CLOCK_HZ = 10_000_000;
  localparam int RC_HZ = 1_000_000;
  localparam int RC_DIVIDE = CLOCK_HZ / RC_HZ;
  localparam int WRITE_RC_CYCLES = 8448;
  localparam int MASTER_WINDOW_CYCLES = 4;
  localparam int READ_STALL_CYCLES = 4;
  localparam int WRITE_STALL_CYCLES = 2;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    PROGRAMMING = 2'b01
  } write_state_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] addr;
    logic [7:0] data;
  } io_request_type;

endpackage

// ### rc_tick_divider.sv
// one-cycle enable at the calibrated oscillator rate
// assumes clk at the package clock rate
`timescale 1ns/1ns
`default_nettype none
module rc_tick_divider (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(eeprom_access_pkg::RC_DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(eeprom_access_pkg::RC_DIVIDE - 1);
  logic [CW-1:0] count;

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  always_comb begin
    tick = (count == LAST);
  end
endmodule
`default_nettype wire

// ### eeprom_access_control.sv
// CPU access controller for the 2K-byte data memory: address, data, control
// assumes one-cycle CPU I/O writes/reads; the CPU honours cpuStall
// Summary of operation
// - write programs the data register byte at the address register location
// - read loads the data register from the addressed location
// - control bits 7..4 read as zero
// - bit 3 enables ready interrupt, gated by the global interrupt enable
// - ready interrupt is a level while the write strobe reads zero
// - write starts only if strobe set within four cycles of master enable
// - write strobe without master enable does nothing
// - master enable clears itself four cycles after being set
// - no write starts while the CPU writes program flash
// - hardware clears write strobe when the write time elapses
// - setting the write strobe stalls the CPU for two cycles
// - read strobe performs the read at once, data ready afterwards
// - a read stalls the CPU for four cycles
// - during a write, reads and address changes are refused
// - write timed by 8448 ticks of the 1 MHz oscillator
// - address is 11 bits; upper five bits read zero
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_control (
  input wire logic clk,
  input wire logic rst,
  input wire eeprom_access_pkg::io_request_type ioRequest,
  output logic [7:0] ioReadData,
  input wire logic globalIrqEnable,
  input wire logic selfProgramActive,
  output logic readyIrq,
  output logic cpuStall,
  output logic writeBusy
);

  // ********************************
  // storage and state
  // ********************************
  logic [7:0] memory [eeprom_access_pkg::DEPTH];
  logic [7:0] eepromDataReg;
  logic [eeprom_access_pkg::ADDR_WIDTH-1:0] eepromAddressReg;
  logic readyIrqEnable;
  logic masterWriteEnable;
  logic writeStrobe;
  logic readStrobe;
  logic [2:0] masterCount;
  logic [2:0] stallCount;
  logic [13:0] rcCount;
  logic rcTick;
  eeprom_access_pkg::write_state_type state;

  localparam logic [2:0] MASTER_LAST = 3'(eeprom_access_pkg::MASTER_WINDOW_CYCLES - 1);
  localparam logic [2:0] READ_STALL = 3'(eeprom_access_pkg::READ_STALL_CYCLES);
  localparam logic [2:0] WRITE_STALL = 3'(eeprom_access_pkg::WRITE_STALL_CYCLES);
  localparam logic [13:0] WRITE_LAST = 14'(eeprom_access_pkg::WRITE_RC_CYCLES - 1);
  // field bounds of the split address, the zero byte used for resets, and the idle stall count
  localparam int ADDR_LOW_MSB = 7;
  localparam int ADDR_HIGH_LSB = 8;
  localparam int ADDR_MSB = eeprom_access_pkg::ADDR_WIDTH - 1;
  localparam int ADDR_HIGH_BITS = eeprom_access_pkg::ADDR_WIDTH - ADDR_HIGH_LSB;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] STALL_IDLE = 3'h0;

  function automatic logic hit(input eeprom_access_pkg::io_request_type req,
                               input logic [5:0] offset);
    hit = req.write && (req.addr == offset);
  endfunction

  // ********************************
  // readback helpers
  // ********************************
  // reserved nibble stays zero because only the four known bits are placed
  function automatic logic [7:0] control_readback(input logic irqEnable,
                                                  input logic masterEnable,
                                                  input logic strobeWrite,
                                                  input logic strobeRead);
    logic [7:0] value;
    value = BYTE_ZERO;
    value[eeprom_access_pkg::READY_IRQ_ENABLE_BIT] = irqEnable;
    value[eeprom_access_pkg::MASTER_WRITE_ENABLE_BIT] = masterEnable;
    value[eeprom_access_pkg::WRITE_STROBE_BIT] = strobeWrite;
    value[eeprom_access_pkg::READ_STROBE_BIT] = strobeRead;
    control_readback = value;
  endfunction

  function automatic logic [7:0] address_high_readback(
      input logic [eeprom_access_pkg::ADDR_WIDTH-1:0] addr);
    address_high_readback = 8'(addr[ADDR_MSB:ADDR_HIGH_LSB]);
  endfunction

  rc_tick_divider rcDivider (
    .clk(clk),
    .rst(rst),
    .tick(rcTick)
  );

  // ********************************
  // control decode
  // ********************************
  logic controlWrite;
  logic armBit;
  logic strobeWriteBit;
  logic strobeReadBit;
  logic armWrite;
  logic startWrite;
  logic startRead;
  logic writeDone;
  // control bits split out once, the arm and strobe decodes below read these
  always_comb begin
    armBit = ioRequest.data[eeprom_access_pkg::MASTER_WRITE_ENABLE_BIT];
    strobeWriteBit = ioRequest.data[eeprom_access_pkg::WRITE_STROBE_BIT];
    strobeReadBit = ioRequest.data[eeprom_access_pkg::READ_STROBE_BIT];
    controlWrite = hit(ioRequest, eeprom_access_pkg::CONTROL_OFFSET) && !cpuStall;
    armWrite = controlWrite && armBit && !strobeWriteBit;
    // strobe counts only while the armed window is open
    startWrite = controlWrite && strobeWriteBit && masterWriteEnable
      && (state == eeprom_access_pkg::IDLE) && !selfProgramActive;
    startRead = controlWrite && strobeReadBit
      && (state == eeprom_access_pkg::IDLE);
    writeDone = (state == eeprom_access_pkg::PROGRAMMING) && rcTick
      && (rcCount == WRITE_LAST);
  end

  // ********************************
  // write sequencer
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= eeprom_access_pkg::IDLE;
    end else begin
      case (state)
        eeprom_access_pkg::IDLE: begin
          if (startWrite) begin
            state <= eeprom_access_pkg::PROGRAMMING;
          end
        end
        eeprom_access_pkg::PROGRAMMING: begin
          if (writeDone) begin
            state <= eeprom_access_pkg::IDLE;
          end
        end
        default: begin
          state <= eeprom_access_pkg::IDLE;
        end
      endcase
    end
  end

  // ********************************
  // write timer
  // ********************************
  // held at zero outside a write, so every write gets the full count;
  // the divider runs free, so the first tick lands 1 to 10 cycles in
  always_ff @(posedge clk) begin
    if (rst) begin
      rcCount <= '0;
    end else if (state != eeprom_access_pkg::PROGRAMMING || writeDone) begin
      rcCount <= '0;
    end else if (rcTick) begin
      rcCount <= rcCount + 14'h0001;
    end
  end

  // memory content has no reset; only the timed write changes it
  always_ff @(posedge clk) begin
    if (writeDone) begin
      memory[eepromAddressReg] <= eepromDataReg;
    end
  end

  // ********************************
  // control register bits
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      readyIrqEnable <= 1'b0;
    end else if (controlWrite) begin
      readyIrqEnable <= ioRequest.data[eeprom_access_pkg::READY_IRQ_ENABLE_BIT];
    end
  end

  // arming again restarts the window rather than extending it
  always_ff @(posedge clk) begin
    if (rst) begin
      masterWriteEnable <= 1'b0;
      masterCount <= '0;
    end else if (armWrite) begin
      masterWriteEnable <= 1'b1;
      masterCount <= '0;
    end else if (startWrite || (masterWriteEnable && masterCount == MASTER_LAST)) begin
      masterWriteEnable <= 1'b0;
    end else if (masterWriteEnable) begin
      masterCount <= masterCount + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      writeStrobe <= 1'b0;
    end else if (startWrite) begin
      writeStrobe <= 1'b1;
    end else if (writeDone) begin
      writeStrobe <= 1'b0;
    end
  end

  // strobe is visible only for the cycle the read completes in
  always_ff @(posedge clk) begin
    if (rst) begin
      readStrobe <= 1'b0;
    end else begin
      readStrobe <= startRead;
    end
  end

  // ********************************
  // data and address registers
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      eepromDataReg <= BYTE_ZERO;
    end else if (startRead) begin
      eepromDataReg <= memory[eepromAddressReg];
    end else if (hit(ioRequest, eeprom_access_pkg::DATA_OFFSET) && !cpuStall) begin
      eepromDataReg <= ioRequest.data;
    end
  end

  // address frozen while programming so the target cannot move
  always_ff @(posedge clk) begin
    if (rst) begin
      eepromAddressReg <= '0;
    end else if (state == eeprom_access_pkg::IDLE && !cpuStall) begin
      if (hit(ioRequest, eeprom_access_pkg::ADDR_LOW_OFFSET)) begin
        eepromAddressReg[ADDR_LOW_MSB:0] <= ioRequest.data;
      end else if (hit(ioRequest, eeprom_access_pkg::ADDR_HIGH_OFFSET)) begin
        eepromAddressReg[ADDR_MSB:ADDR_HIGH_LSB] <=
          ioRequest.data[ADDR_HIGH_BITS-1:0] & eeprom_access_pkg::ADDR_HIGH_MASK;
      end
    end
  end

  // ********************************
  // CPU stall
  // ********************************
  // reads and writes share one counter; a read outranks a write
  always_ff @(posedge clk) begin
    if (rst) begin
      stallCount <= '0;
    end else if (startRead) begin
      stallCount <= READ_STALL;
    end else if (startWrite) begin
      stallCount <= WRITE_STALL;
    end else if (stallCount != STALL_IDLE) begin
      stallCount <= stallCount - 3'h1;
    end
  end

  // ********************************
  // outputs
  // ********************************
  logic [7:0] next_ioReadData;
  always_comb begin
    case (ioRequest.addr)
      eeprom_access_pkg::CONTROL_OFFSET: begin
        next_ioReadData = control_readback(readyIrqEnable, masterWriteEnable,
                                           writeStrobe, readStrobe);
      end
      eeprom_access_pkg::DATA_OFFSET: begin
        next_ioReadData = eepromDataReg;
      end
      eeprom_access_pkg::ADDR_LOW_OFFSET: begin
        next_ioReadData = eepromAddressReg[ADDR_LOW_MSB:0];
      end
      eeprom_access_pkg::ADDR_HIGH_OFFSET: begin
        next_ioReadData = address_high_readback(eepromAddressReg);
      end
      default: begin
        next_ioReadData = BYTE_ZERO;
      end
    endcase
  end

  // registered so the CPU reads a settled byte one cycle after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      ioReadData <= BYTE_ZERO;
    end else begin
      ioReadData <= next_ioReadData;
    end
  end

  // ********************************
  // combinational handshakes
  // ********************************
  always_comb begin
    readyIrq = readyIrqEnable && globalIrqEnable && !writeStrobe;
    cpuStall = (stallCount != STALL_IDLE);
    writeBusy = (state == eeprom_access_pkg::PROGRAMMING);
  end

endmodule
`default_nettype wire

// ### eeprom_access_control_checker.sv
// port assertions for the data-memory access controller
// assumes bind onto eeprom_access_control, one clock domain
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_control_checker (
  input wire logic clk,
  input wire logic rst,
  input wire eeprom_access_pkg::io_request_type ioRequest,
  input wire logic [7:0] ioReadData,
  input wire logic globalIrqEnable,
  input wire logic selfProgramActive,
  input wire logic readyIrq,
  input wire logic cpuStall,
  input wire logic writeBusy
);
  // ****************
  // helpers
  // ****************
  // divider phase is free at the strobe, hence the slack
  localparam int BUSY_MIN = 84470;
  localparam int BUSY_MAX = 84490;
  localparam logic [5:0] CTL = eeprom_access_pkg::CONTROL_OFFSET;
  localparam logic [5:0] AHI = eeprom_access_pkg::ADDR_HIGH_OFFSET;
  logic [16:0] busyCnt;
  logic ctrlWr;
  assign ctrlWr = ioRequest.write && ioRequest.addr == CTL;
  always_ff @(posedge clk) begin
    if (rst || !writeBusy) begin
      busyCnt <= 17'h00000;
    end else begin
      busyCnt <= busyCnt + 17'h00001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_irq_gate: assert property (readyIrq |-> globalIrqEnable)
    else $error("ready interrupt without global enable");
  chk_irq_level: assert property (writeBusy |-> !readyIrq)
    else $error("ready interrupt during a write");
  chk_ctrl_reserved: assert property (
    ioRequest.addr == CTL |=> ioReadData[7:4] == 4'h0)
    else $error("control upper bits not zero");
  chk_addr_upper: assert property (
    ioRequest.addr == AHI |=> ioReadData[7:3] == 5'h00)
    else $error("address upper bits not zero");
  chk_write_stall: assert property (
    $rose(writeBusy) |-> cpuStall ##1 cpuStall ##1 !cpuStall)
    else $error("write stall not two cycles");
  chk_write_cause: assert property (
    $rose(writeBusy) |-> $past(ctrlWr && ioRequest.data[1] && !selfProgramActive))
    else $error("write started without a strobe");
  chk_read_stall: assert property (
    ctrlWr && ioRequest.data[1:0] == 2'b01 && !cpuStall && !writeBusy
    |=> cpuStall [*4] ##1 !cpuStall)
    else $error("read stall not four cycles");
  chk_busy_max: assert property (writeBusy |-> busyCnt <= BUSY_MAX)
    else $error("write too long");
  chk_busy_min: assert property (
    $fell(writeBusy) && !$past(rst) |-> busyCnt >= BUSY_MIN)
    else $error("write too short");
endmodule
bind eeprom_access_control eeprom_access_control_checker chk (.clk(clk), .rst(rst),
  .ioRequest(ioRequest), .ioReadData(ioReadData), .globalIrqEnable(globalIrqEnable),
  .selfProgramActive(selfProgramActive), .readyIrq(readyIrq), .cpuStall(cpuStall),
  .writeBusy(writeBusy));
`default_nettype wire

// ### cpu_io_model.sv
// CPU core model issuing I/O register accesses
// assumes the core freezes while cpuStall is high
`timescale 1ns/1ns
`default_nettype none
module cpu_io_model (
  input wire logic clk,
  input wire logic cpuStall,
  input wire logic writeBusy,
  output var eeprom_access_pkg::io_request_type ioRequest,
  output logic globalIrqEnable,
  output logic selfProgramActive,
  output logic rdDone
);
  initial begin
    ioRequest = '0;
    globalIrqEnable = 1'b0;
    selfProgramActive = 1'b0;
    rdDone = 1'b0;
  end
  // ****************
  // access tasks
  // ****************
  // held until an edge with no stall takes it
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 ioRequest = '{write: 1'b1, read: 1'b0, addr: a, data: d};
    @(negedge clk);
    while (cpuStall) @(negedge clk);
    @(posedge clk);
    #1 ioRequest.write = 1'b0;
  endtask
  task automatic get(input logic [5:0] a);
    @(posedge clk);
    #1 ioRequest = '{write: 1'b0, read: 1'b0, addr: a, data: 8'h00};
    @(posedge clk);
    #1 rdDone = 1'b1;
    @(posedge clk);
    #1 rdDone = 1'b0;
  endtask
  task automatic flags(input logic g, input logic s);
    @(posedge clk);
    #1 globalIrqEnable = g;
    selfProgramActive = s;
  endtask
  task automatic store(input logic [10:0] a, input logic [7:0] d);
    while (writeBusy || selfProgramActive) begin
      @(posedge clk);
      #1;
    end
    globalIrqEnable = 1'b0;
    put(eeprom_access_pkg::ADDR_HIGH_OFFSET, {5'h00, a[10:8]});
    put(eeprom_access_pkg::ADDR_LOW_OFFSET, a[7:0]);
    put(eeprom_access_pkg::DATA_OFFSET, d);
    put(eeprom_access_pkg::CONTROL_OFFSET, 8'h04);
    put(eeprom_access_pkg::CONTROL_OFFSET, 8'h02);
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the data-memory access controller
// assumes cpu_io_model drives every request input
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [5:0] CTL = eeprom_access_pkg::CONTROL_OFFSET;
  localparam logic [5:0] DAT = eeprom_access_pkg::DATA_OFFSET;
  localparam logic [5:0] ALO = eeprom_access_pkg::ADDR_LOW_OFFSET;
  localparam logic [5:0] AHI = eeprom_access_pkg::ADDR_HIGH_OFFSET;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic probe = 1'b0;
  logic rdDone, globalIrqEnable, selfProgramActive, readyIrq, cpuStall, writeBusy;
  logic [7:0] ioReadData, d;
  logic [10:0] a;
  eeprom_access_pkg::io_request_type ioRequest;
  logic [7:0] expQ[$];
  int miscompares = 0;
  int cmpCount = 0;
  int cycles = 0;
  int n;
  always #50 clk = ~clk;
  eeprom_access_control dut (.clk(clk), .rst(rst), .ioRequest(ioRequest),
    .ioReadData(ioReadData), .globalIrqEnable(globalIrqEnable),
    .selfProgramActive(selfProgramActive), .readyIrq(readyIrq), .cpuStall(cpuStall),
    .writeBusy(writeBusy));
  cpu_io_model cpu (.clk(clk), .cpuStall(cpuStall), .writeBusy(writeBusy),
    .ioRequest(ioRequest), .globalIrqEnable(globalIrqEnable),
    .selfProgramActive(selfProgramActive), .rdDone(rdDone));
  // ****************
  // checking
  // ****************
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic expR(input logic [7:0] e, input logic [5:0] o);
    expQ.push_back(e);
    cpu.get(o);
  endtask
  // flag byte: ready irq, stall, busy
  task automatic expF(input logic [7:0] e);
    expQ.push_back(e);
    probe = 1'b1;
    @(negedge clk);
    #1 probe = 1'b0;
  endtask
  always @(negedge clk) begin
    if (rdDone || probe) begin
      cmp(expQ.pop_front(), rdDone ? ioReadData : {5'h00, readyIrq, cpuStall, writeBusy});
    end
  end
  // one write is about 84.5k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    void'($urandom(94713));
    a = 11'($urandom());
    d = 8'($urandom());
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    expR(8'h00, CTL);
    cpu.put(CTL, 8'hF8);
    expR(8'h08, CTL);
    cpu.flags(1'b1, 1'b0);
    expF(8'h04);
    cpu.flags(1'b0, 1'b0);
    expF(8'h00);
    cpu.put(AHI, 8'hFF);
    expR(8'h07, AHI);
    cpu.put(CTL, 8'h02);
    expR(8'h00, CTL);
    cpu.put(CTL, 8'h04);
    expR(8'h04, CTL);
    expR(8'h00, CTL);
    cpu.put(CTL, 8'h02);
    expF(8'h00);
    cpu.flags(1'b0, 1'b1);
    cpu.put(CTL, 8'h04);
    cpu.put(CTL, 8'h02);
    expF(8'h00);
    cpu.flags(1'b0, 1'b0);
    cpu.store(a, d);
    expF(8'h03);
    cpu.put(ALO, ~a[7:0]);
    expR(a[7:0], ALO);
    cpu.put(CTL, 8'h08);
    cpu.flags(1'b1, 1'b0);
    expF(8'h01);
    n = 0;
    while (writeBusy === 1'b1 && n < 90000) begin
      @(posedge clk);
      #1 n++;
    end
    expR(8'h08, CTL);
    expF(8'h04);
    cpu.put(DAT, ~d);
    cpu.put(CTL, 8'h01);
    expF(8'h02);
    expR(8'h00, CTL);
    expR(d, DAT);
    conclude();
  end
endmodule
`default_nettype wire
